// ==== hw/pfp_pkg.sv ====
package pfp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PFP_NFLAG = 8;
  localparam int PFP_NIRQ = 10;
  localparam int PFP_NSTRAP = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] PFP_OFF_DIR = 8'h00;
  localparam logic [7:0] PFP_OFF_VAL = 8'h04;
  localparam logic [7:0] PFP_OFF_FIXED = 8'h08;
  localparam logic [7:0] PFP_OFF_SYSCTL = 8'h0C;
  localparam logic [7:0] PFP_OFF_STRAP = 8'h10;
  localparam logic [7:0] PFP_OFF_ISTAT = 8'h14;
  localparam logic [7:0] PFP_OFF_INTERRUPT_MASK_REG = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int PFP_FIX_A_BIT = 0;
  localparam int PFP_FIX_B_BIT = 1;
  localparam int PFP_FIX_C_BIT = 2;
  localparam int PFP_FIX_FO_BIT = 3;
  localparam int PFP_FIX_FI_BIT = 4;
  localparam int PFP_SP1_CFG_BIT = 10;
  localparam int PFP_MODEC_BIT = 2;
  localparam int PFP_STRAP_VALID_BIT = 4;
  localparam int PFP_IRQ_A_BIT = 8;
  localparam int PFP_IRQ_B_BIT = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [PFP_NFLAG-1:0] PFP_RST_DIR = 8'h00;
  localparam logic [PFP_NFLAG-1:0] PFP_RST_VAL = 8'h00;
  localparam logic [3:0] PFP_RST_FIXED = 4'h0;
  localparam logic PFP_RST_SP1_CFG = 1'b1;
  localparam logic [PFP_NIRQ-1:0] PFP_RST_INTERRUPT_MASK_REG = 10'h000;
  localparam logic [PFP_NSTRAP-1:0] PFP_RST_STRAP = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic emu_rst;
    logic irq_b_n;
    logic irq_a_n;
    logic ffi;
    logic [PFP_NFLAG-1:0] flags;
  } pfp_pins_t;

  typedef enum logic [1:0] {
    PFP_ST_FILL,
    PFP_ST_SETTLE,
    PFP_ST_LATCH,
    PFP_ST_RUN
  } pfp_strap_st_t;

endpackage

// ==== hw/pfp_sync.sv ====
`timescale 1ns/1ns
module pfp_sync
  import pfp_pkg::*;
#(
  parameter int WIDTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // Two-stage synchroniser, first stage read only by second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ==== hw/pfp_flag_port.sv ====
`timescale 1ns/1ns
module pfp_flag_port
  import pfp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PFP_NFLAG-1:0] prog_flag_pin_i,
  output logic [PFP_NFLAG-1:0] prog_flag_pin_o,
  output logic [PFP_NFLAG-1:0] prog_flag_pin_oe,
  input wire logic fixed_flag_in,
  output logic fixed_flag_out,
  output logic fixed_flag_out_oe,
  output logic dedicated_out_flag_a,
  output logic dedicated_out_flag_b,
  output logic dedicated_out_flag_c,
  input wire logic ext_interrupt_a_n,
  input wire logic ext_interrupt_b_n,
  input wire logic emu_chip_reset,
  output logic serial_port_one_en,
  output logic host_mode,
  output logic strap_valid,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helper
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == PFP_OFF_DIR) || (a == PFP_OFF_VAL) || (a == PFP_OFF_FIXED) ||
                (a == PFP_OFF_SYSCTL) || (a == PFP_OFF_STRAP) || (a == PFP_OFF_ISTAT) ||
                (a == PFP_OFF_INTERRUPT_MASK_REG);
  endfunction

  pfp_pins_t pin_raw;
  pfp_pins_t pin_q;
  logic [PFP_NFLAG-1:0] dir_r;
  logic [PFP_NFLAG-1:0] val_r;
  logic [3:0] fixed_r;
  logic sp1_cfg_r;
  logic [PFP_NIRQ-1:0] istat_r;
  logic [PFP_NIRQ-1:0] interrupt_mask_reg_r;
  logic [PFP_NIRQ-1:0] lvl_prev_r;
  logic [PFP_NSTRAP-1:0] strap_r;
  pfp_strap_st_t strap_st_r;
  logic emu_prev_r;
  logic chip_rst_r;
  logic [31:0] prdata_r;
  logic [PFP_NFLAG-1:0] eff;
  logic [PFP_NIRQ-1:0] lvl;
  logic [PFP_NIRQ-1:0] set_vec;
  logic [PFP_NIRQ-1:0] clr_vec;
  logic [31:0] rd_data;
  logic wr_en;
  logic setup;
  logic flag_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pin_raw = '{emu_rst: emu_chip_reset, irq_b_n: ext_interrupt_b_n, irq_a_n: ext_interrupt_a_n,
                     ffi: fixed_flag_in, flags: prog_flag_pin_i};

  pfp_sync #(
    .WIDTH($bits(pfp_pins_t))
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_raw),
    .q(pin_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave handshake
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && is_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign prdata = prdata_r;

  // Emulation chip reset, one pulse per rising command edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emu_prev_r <= 1'b0;
      chip_rst_r <= 1'b0;
    end else begin
      emu_prev_r <= pin_q.emu_rst;
      chip_rst_r <= pin_q.emu_rst && !emu_prev_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction and value registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= PFP_RST_DIR;
    end else if (chip_rst_r) begin
      dir_r <= PFP_RST_DIR;
    end else if (wr_en && paddr == PFP_OFF_DIR) begin
      dir_r <= pwdata[PFP_NFLAG-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_r <= PFP_RST_VAL;
    end else if (chip_rst_r) begin
      val_r <= PFP_RST_VAL;
    end else if (wr_en && paddr == PFP_OFF_VAL) begin
      val_r <= pwdata[PFP_NFLAG-1:0];
    end
  end

  assign prog_flag_pin_o = val_r;
  assign prog_flag_pin_oe = dir_r;

  assign eff = (dir_r & val_r) | (~dir_r & pin_q.flags);

  ////////////////////////////////////////////////////////////////////////////
  // Fixed flags and serial port configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_r <= PFP_RST_FIXED;
    end else if (chip_rst_r) begin
      fixed_r <= PFP_RST_FIXED;
    end else if (wr_en && paddr == PFP_OFF_FIXED) begin
      fixed_r <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp1_cfg_r <= PFP_RST_SP1_CFG;
    end else if (chip_rst_r) begin
      sp1_cfg_r <= PFP_RST_SP1_CFG;
    end else if (wr_en && paddr == PFP_OFF_SYSCTL) begin
      sp1_cfg_r <= pwdata[PFP_SP1_CFG_BIT];
    end
  end

  assign flag_mode = !sp1_cfg_r;
  assign serial_port_one_en = sp1_cfg_r;

  assign dedicated_out_flag_a = fixed_r[PFP_FIX_A_BIT];
  assign dedicated_out_flag_b = fixed_r[PFP_FIX_B_BIT];
  assign dedicated_out_flag_c = fixed_r[PFP_FIX_C_BIT];

  // fixed pair only in alternate mode
  assign fixed_flag_out = fixed_r[PFP_FIX_FO_BIT];
  assign fixed_flag_out_oe = flag_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_st_r <= PFP_ST_FILL;
    end else if (chip_rst_r) begin
      strap_st_r <= PFP_ST_FILL;
    end else begin
      unique case (strap_st_r)
        PFP_ST_FILL: begin
          strap_st_r <= PFP_ST_SETTLE;
        end
        PFP_ST_SETTLE: begin
          strap_st_r <= PFP_ST_LATCH;
        end
        PFP_ST_LATCH: begin
          strap_st_r <= PFP_ST_RUN;
        end
        PFP_ST_RUN: begin
          strap_st_r <= PFP_ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_r <= PFP_RST_STRAP;
    end else if (strap_st_r == PFP_ST_LATCH) begin
      strap_r <= pin_q.flags[PFP_NSTRAP-1:0];
    end
  end

  assign host_mode = strap_r[PFP_MODEC_BIT];
  assign strap_valid = (strap_st_r == PFP_ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events, active-low assertion edges
  assign lvl = {pin_q.irq_b_n, pin_q.irq_a_n, eff};
  // own drive or external flag edges both count, interrupt pins only in flag mode
  assign set_vec = lvl_prev_r & ~lvl & {flag_mode, flag_mode, {PFP_NFLAG{1'b1}}};
  assign clr_vec = (wr_en && paddr == PFP_OFF_ISTAT) ? pwdata[PFP_NIRQ-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_prev_r <= '1;
    end else begin
      lvl_prev_r <= lvl;
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= '0;
    end else if (chip_rst_r) begin
      istat_r <= '0;
    end else begin
      istat_r <= (istat_r & ~clr_vec) | set_vec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_mask_reg_r <= PFP_RST_INTERRUPT_MASK_REG;
    end else if (chip_rst_r) begin
      interrupt_mask_reg_r <= PFP_RST_INTERRUPT_MASK_REG;
    end else if (wr_en && paddr == PFP_OFF_INTERRUPT_MASK_REG) begin
      interrupt_mask_reg_r <= pwdata[PFP_NIRQ-1:0];
    end
  end

  assign irq = |(istat_r & interrupt_mask_reg_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, captured in setup phase
  always_comb begin
    rd_data = '0;
    unique case (paddr)
      PFP_OFF_DIR: rd_data[PFP_NFLAG-1:0] = dir_r;
      PFP_OFF_VAL: rd_data[PFP_NFLAG-1:0] = eff;
      PFP_OFF_FIXED: begin
        rd_data[3:0] = fixed_r;
        rd_data[PFP_FIX_FI_BIT] = flag_mode && pin_q.ffi;
      end
      PFP_OFF_SYSCTL: rd_data[PFP_SP1_CFG_BIT] = sp1_cfg_r;
      PFP_OFF_STRAP: begin
        rd_data[PFP_NSTRAP-1:0] = strap_r;
        rd_data[PFP_STRAP_VALID_BIT] = strap_valid;
      end
      PFP_OFF_ISTAT: rd_data[PFP_NIRQ-1:0] = istat_r;
      PFP_OFF_INTERRUPT_MASK_REG: rd_data[PFP_NIRQ-1:0] = interrupt_mask_reg_r;
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup && !pwrite) begin
      prdata_r <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_dir_input: assert property (@(posedge pclk) disable iff (!presetn)
    chip_rst_r |=> (prog_flag_pin_oe == '0)) else $error("flag pins not inputs after chip reset");

  a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == PFP_OFF_DIR && !chip_rst_r) |=> (prog_flag_pin_oe == $past(pwdata[7:0])))
    else $error("direction write not applied");

  a_out_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == PFP_OFF_VAL) |=>
      ((prdata[7:0] & $past(dir_r)) == ($past(val_r) & $past(dir_r))))
    else $error("output bit did not read driven value");

  a_in_synced: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == PFP_OFF_VAL) |=>
      ((prdata[7:0] & ~$past(dir_r)) == ($past(prog_flag_pin_i, 3) & ~$past(dir_r))))
    else $error("input bit not two-stage synchronised");

  a_fixed_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == PFP_OFF_SYSCTL && !chip_rst_r) |=> (fixed_flag_out_oe == !$past(pwdata[10])))
    else $error("fixed flag enable wrong for serial port setting");

  a_dedicated_free: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == PFP_OFF_FIXED && !chip_rst_r) |=>
      (dedicated_out_flag_b == $past(pwdata[1])) && (dedicated_out_flag_c == $past(pwdata[2])))
    else $error("dedicated flag not updated");

  a_flag_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
    (set_vec[0] && interrupt_mask_reg_r[0] && !chip_rst_r && !(wr_en && paddr == PFP_OFF_INTERRUPT_MASK_REG)) |=> irq)
    else $error("enabled flag interrupt not raised");

  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (|set_vec && !chip_rst_r) |=> ((istat_r & $past(set_vec)) == $past(set_vec)))
    else $error("interrupt event lost");

  a_strap_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (strap_st_r == PFP_ST_LATCH && !chip_rst_r) |=> (strap_r == $past(pin_q.flags[3:0])))
    else $error("straps not latched");

  a_mode_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (strap_valid && !chip_rst_r) |=> $stable(host_mode)) else $error("memory mode changed while running");

  a_chip_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (chip_rst_r ##1 !chip_rst_r [*4]) |-> strap_valid && !$past(strap_valid, 3))
    else $error("chip reset did not re-latch straps");

endmodule

// ==== bench/pfp_board.sv ====
`timescale 1ns/1ns
module pfp_board (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] drive,
  input wire logic [7:0] drive_en,
  output logic [7:0] pin
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin level: device drive wins, then board drive, else pull-up
  // undriven pins pulled high
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      pin[n] = pin_oe[n] ? pin_o[n] : (drive_en[n] ? drive[n] : 1'b1);
    end
  end
endmodule

// ==== bench/test_programmable_flag_port.sv ====
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module test_programmable_flag_port;
  import pfp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pin, pin_o, pin_oe;
  logic [7:0] drive = 8'hFF;
  logic [7:0] drive_en = 8'hFF;
  logic fixed_flag_in = 1'b0;
  logic fixed_flag_out, fixed_flag_out_oe, flag_a, flag_b, flag_c;
  logic ext_a_n = 1'b1;
  logic ext_b_n = 1'b1;
  logic emu_chip_reset = 1'b0;
  logic serial_port_one_en, host_mode, strap_valid, irq;
  int bad_count = 0;
  int compares = 0;
  logic [31:0] seed = 32'h00016E4E;
  logic [31:0] q;
  logic err;
  logic [3:0] pat, pat2;
  logic [7:0] dir, val, ext;

  ////////////////////////////////////////////////////////////////////////////
  // Design and board model
  pfp_flag_port pfp_flag_port_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_flag_pin_i(pin), .prog_flag_pin_o(pin_o), .prog_flag_pin_oe(pin_oe),
    .fixed_flag_in(fixed_flag_in), .fixed_flag_out(fixed_flag_out), .fixed_flag_out_oe(fixed_flag_out_oe),
    .dedicated_out_flag_a(flag_a), .dedicated_out_flag_b(flag_b), .dedicated_out_flag_c(flag_c),
    .ext_interrupt_a_n(ext_a_n), .ext_interrupt_b_n(ext_b_n), .emu_chip_reset(emu_chip_reset),
    .serial_port_one_en(serial_port_one_en), .host_mode(host_mode), .strap_valid(strap_valid), .irq(irq));
  pfp_board pfp_board_i (.pin_o(pin_o), .pin_oe(pin_oe), .drive(drive), .drive_en(drive_en), .pin(pin));

  // Clock
  always #2 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic [7:0] exp_val(logic [7:0] d, logic [7:0] v, logic [7:0] e);
    return (d & v) | (~d & e);
  endfunction

  task results();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      results();
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] wq;
    logic we;
    apb(1'b1, a, d, wq, we);
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, q, err);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #40000;
    bad_count++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    pat = 4'(xs());
    drive = {4'hF, pat};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("pin_oe", 8'h00, pin_oe)
    `CHK("pready", 1'b1, pready)
    `CHK("strap_valid", 1'b1, strap_valid)
    rd(PFP_OFF_DIR);
    `CHK("dir", 32'h0, q)
    rd(PFP_OFF_SYSCTL);
    `CHK("sp1cfg", 1'b1, q[PFP_SP1_CFG_BIT])
    rd(PFP_OFF_STRAP);
    `CHK("strap", {27'h0, 1'b1, pat}, q)
    `CHK("host_mode", pat[2], host_mode)
    // Direction and value, corners then random
    for (int i = 0; i < 8; i++) begin
      dir = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'(xs());
      val = 8'(xs());
      ext = 8'(xs());
      wr(PFP_OFF_DIR, {24'h0, dir});
      wr(PFP_OFF_VAL, {24'h0, val});
      drive <= ext;
      repeat (4) @(posedge pclk);
      rd(PFP_OFF_VAL);
      `CHK("val", exp_val(dir, val, ext), q[7:0])
      `CHK("oe", dir, pin_oe)
      `CHK("pin_o", val, pin_o)
    end
    // Fixed flags and serial port setup
    fixed_flag_in <= 1'b1;
    wr(PFP_OFF_FIXED, 32'h0000000F);
    `CHK("dedicated", 3'h7, {flag_c, flag_b, flag_a})
    `CHK("fo_oe", 1'b0, fixed_flag_out_oe)
    rd(PFP_OFF_FIXED);
    `CHK("fi_off", 1'b0, q[PFP_FIX_FI_BIT])
    wr(PFP_OFF_SYSCTL, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK("fo_oe", 1'b1, fixed_flag_out_oe)
    `CHK("sp1_en", 1'b0, serial_port_one_en)
    `CHK("fo", 1'b1, fixed_flag_out)
    rd(PFP_OFF_FIXED);
    `CHK("fi_on", 1'b1, q[PFP_FIX_FI_BIT])
    // Interrupt from own flag output
    wr(PFP_OFF_DIR, 32'h01);
    wr(PFP_OFF_VAL, 32'h01);
    wr(PFP_OFF_ISTAT, 32'h3FF);
    wr(PFP_OFF_INTERRUPT_MASK_REG, 32'h001);
    `CHK("irq_idle", 1'b0, irq)
    wr(PFP_OFF_VAL, 32'h00);
    repeat (4) @(posedge pclk);
    `CHK("irq_own", 1'b1, irq)
    wr(PFP_OFF_ISTAT, 32'h001);
    repeat (2) @(posedge pclk);
    `CHK("irq_clr", 1'b0, irq)
    // Interrupt from external pin, then a masked one
    wr(PFP_OFF_INTERRUPT_MASK_REG, 32'h100);
    ext_a_n <= 1'b0;
    repeat (5) @(posedge pclk);
    `CHK("irq_ext", 1'b1, irq)
    ext_a_n <= 1'b1;
    wr(PFP_OFF_ISTAT, 32'h100);
    ext_b_n <= 1'b0;
    repeat (5) @(posedge pclk);
    `CHK("irq_masked", 1'b0, irq)
    rd(PFP_OFF_ISTAT);
    `CHK("stat_b", 1'b1, q[PFP_IRQ_B_BIT])
    rd(PFP_OFF_INTERRUPT_MASK_REG);
    `CHK("interrupt_mask_reg", 32'h100, q)
    // Emulation chip reset re-latches straps
    pat2 = ~pat;
    wr(PFP_OFF_DIR, 32'hF0);
    drive <= {4'hF, pat2};
    emu_chip_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    emu_chip_reset <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("strap_busy", 1'b0, strap_valid)
    repeat (9) @(posedge pclk);
    `CHK("sp1_en2", 1'b1, serial_port_one_en)
    rd(PFP_OFF_DIR);
    `CHK("dir_soft", 32'h0, q)
    rd(PFP_OFF_STRAP);
    `CHK("strap2", {27'h0, 1'b1, pat2}, q)
    `CHK("host_mode2", pat2[2], host_mode)
    // Unmapped address
    apb(1'b0, 8'h40, 32'h0, q, err);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, q)
    results();
  end
endmodule
